// >>> hdl/prtc_ctrl.sv
// Power-dip ride-through supervisor with its AXI4-Lite register file.
// Assumes bus_level in 0.1 % of rated DC bus voltage and frequencies in 0.01 Hz.
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module prtc_ctrl #(
  parameter int TENTH_CYC = prtc_pkg::TENTH_S_CYC,
  parameter int PI_CYC = prtc_pkg::PI_PERIOD_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [15:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [15:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] bus_level,
  input wire logic supply_lost,
  input wire logic start_cmd,
  input wire logic [15:0] freq_target,
  input wire logic [15:0] accel_time,
  input wire logic [15:0] normal_decel_time,
  output logic [15:0] freq_out,
  output logic uv_fault,
  output logic irq
);
  localparam int UNIT_CYC = TENTH_CYC / prtc_pkg::MAX_FREQ;

  typedef struct packed {
    logic [15:0] mode;
    logic [15:0] dis_lvl;
    logic [15:0] en_lvl;
    logic [15:0] recov;
    logic [15:0] kp;
    logic [15:0] ki;
    logic [15:0] decel;
    logic [prtc_pkg::ST_W-1:0] status;
    logic [prtc_pkg::ST_W-1:0] mask;
    prtc_pkg::prtc_state_type fsm;
    logic aw_v;
    logic [13:0] aw_idx;
    logic w_v;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic b_v;
    logic [1:0] bresp;
    logic r_v;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] tcnt;
    logic [15:0] units;
    logic [31:0] pcnt;
    logic apply;
    logic uv;
  } prtc_ctrl_st_type;

  prtc_ctrl_st_type s_q, s_d;
  logic pi_upd;
  logic ramp_run;
  logic [15:0] ramp_target;
  logic [31:0] ramp_step;
  logic [15:0] pi_delta;
  logic [prtc_pkg::ST_W-1:0] ev;
  logic [15:0] wval;

  // ---------------------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------------------
  // Limits a written value to its allowed range.
  function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo,
                                        input logic [15:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // Turns a time setting in 0.1 s into cycles per frequency unit, at least one.
  function automatic logic [31:0] step_of(input logic [15:0] t);
    logic [47:0] p;
    p = 48'(t) * 48'(UNIT_CYC);
    step_of = (p == '0) ? 32'h1 : p[31:0];
  endfunction

  // Tells whether an index is one of the mapped registers.
  function automatic logic mapped(input logic [13:0] idx);
    mapped = (idx >= prtc_pkg::IDX_MODE && idx <= prtc_pkg::IDX_DECEL) ||
             (idx >= prtc_pkg::IDX_STATUS && idx <= prtc_pkg::IDX_STATE);
  endfunction

  // ---------------------------------------------------------------------------
  // Ramp generator and bus regulator
  // ---------------------------------------------------------------------------
  prtc_ramp u_ramp (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .run(ramp_run),
    .target(ramp_target),
    .step_cyc(ramp_step),
    .sub_en(s_q.apply),
    .sub_amt(pi_delta),
    .freq(freq_out)
  );

  prtc_pi u_pi (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .active(s_q.fsm == prtc_pkg::PRTC_DIP && s_q.mode == prtc_pkg::MODE_HOLD),
    .upd(pi_upd),
    .err(17'($signed({1'b0, s_q.en_lvl}) - $signed({1'b0, bus_level}))),
    .kp(s_q.kp),
    .ki(s_q.ki),
    .delta(pi_delta)
  );

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    ev = '0;
    pi_upd = 1'b0;
    ramp_run = 1'b0;
    ramp_target = freq_target;
    ramp_step = (freq_target > freq_out) ? step_of(accel_time) : step_of(normal_decel_time);
    wval = '0;
    s_d.apply = 1'b0;
    s_d.uv = bus_level < prtc_pkg::UV_TRIP;
    ev[prtc_pkg::ST_UV] = s_d.uv && !s_q.uv;

    unique case (s_q.fsm)
      prtc_pkg::PRTC_RUN: begin
        ramp_run = 1'b1;
        if (s_q.mode != prtc_pkg::MODE_OFF && supply_lost &&
            bus_level < s_q.en_lvl && freq_out != prtc_pkg::ZERO16) begin
          s_d.fsm = prtc_pkg::PRTC_DIP;
          s_d.pcnt = '0;
          ev[prtc_pkg::ST_DIP] = 1'b1;
        end
      end
      prtc_pkg::PRTC_DIP: begin
        if (s_q.mode == prtc_pkg::MODE_STOP) begin
          ramp_run = 1'b1;
          ramp_target = prtc_pkg::ZERO16;
          ramp_step = step_of(s_q.decel);
          if (!supply_lost && s_q.status[prtc_pkg::ST_RET] == 1'b0) begin
            ev[prtc_pkg::ST_RET] = 1'b1;
          end
          if (freq_out == prtc_pkg::ZERO16) begin
            s_d.fsm = prtc_pkg::PRTC_STOPPED;
            ev[prtc_pkg::ST_STOP] = 1'b1;
          end
        end else if (s_q.mode == prtc_pkg::MODE_HOLD) begin
          if (s_q.pcnt + 32'h1 >= 32'(PI_CYC)) begin
            s_d.pcnt = '0;
            pi_upd = bus_level <= s_q.dis_lvl;
          end else begin
            s_d.pcnt = s_q.pcnt + 32'h1;
          end
          s_d.apply = pi_upd;
          if (!supply_lost) begin
            s_d.fsm = prtc_pkg::PRTC_RECOVER;
            s_d.tcnt = '0;
            s_d.units = '0;
            ev[prtc_pkg::ST_RET] = 1'b1;
          end
        end else begin
          s_d.fsm = prtc_pkg::PRTC_RUN;
        end
      end
      prtc_pkg::PRTC_RECOVER: begin
        if (s_q.units >= s_q.recov) begin
          s_d.fsm = prtc_pkg::PRTC_RUN;
        end else if (s_q.tcnt + 32'h1 >= 32'(TENTH_CYC)) begin
          s_d.tcnt = '0;
          s_d.units = s_q.units + 16'h1;
        end else begin
          s_d.tcnt = s_q.tcnt + 32'h1;
        end
        if (supply_lost && bus_level < s_q.en_lvl) begin
          s_d.fsm = prtc_pkg::PRTC_DIP;
          ev[prtc_pkg::ST_DIP] = 1'b1;
        end
      end
      prtc_pkg::PRTC_STOPPED: begin
        ramp_target = prtc_pkg::ZERO16;
        if (start_cmd) begin
          s_d.fsm = prtc_pkg::PRTC_RUN;
        end
      end
    endcase

    // -------------------------------------------------------------------------
    // AXI4-Lite slave
    // -------------------------------------------------------------------------
    if (s_axi_awvalid && s_axi_awready) begin
      s_d.aw_v = 1'b1;
      s_d.aw_idx = s_axi_awaddr[15:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_d.w_v = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
    end
    if (s_q.b_v && s_axi_bready) begin
      s_d.b_v = 1'b0;
    end
    if (s_q.aw_v && s_q.w_v) begin
      s_d.aw_v = 1'b0;
      s_d.w_v = 1'b0;
      s_d.b_v = 1'b1;
      s_d.bresp = mapped(s_q.aw_idx) ? prtc_pkg::RESP_OKAY : prtc_pkg::RESP_SLVERR;
      unique case (s_q.aw_idx)
        prtc_pkg::IDX_MODE: wval = s_q.mode;
        prtc_pkg::IDX_DIS_LVL: wval = s_q.dis_lvl;
        prtc_pkg::IDX_EN_LVL: wval = s_q.en_lvl;
        prtc_pkg::IDX_RECOV: wval = s_q.recov;
        prtc_pkg::IDX_KP: wval = s_q.kp;
        prtc_pkg::IDX_KI: wval = s_q.ki;
        prtc_pkg::IDX_DECEL: wval = s_q.decel;
        prtc_pkg::IDX_MASK: wval = 16'(s_q.mask);
        default: wval = '0;
      endcase
      if (s_q.wstrb[0]) begin
        wval[7:0] = s_q.wdata[7:0];
      end
      if (s_q.wstrb[1]) begin
        wval[15:8] = s_q.wdata[15:8];
      end
      unique case (s_q.aw_idx)
        prtc_pkg::IDX_MODE: s_d.mode = clamp(wval, prtc_pkg::ZERO16, prtc_pkg::MODE_MAX);
        prtc_pkg::IDX_DIS_LVL: s_d.dis_lvl = clamp(wval, prtc_pkg::DIS_MIN, prtc_pkg::LVL_MAX);
        prtc_pkg::IDX_EN_LVL: s_d.en_lvl = clamp(wval, prtc_pkg::EN_MIN, prtc_pkg::LVL_MAX);
        prtc_pkg::IDX_RECOV: s_d.recov = clamp(wval, prtc_pkg::ZERO16, prtc_pkg::RECOV_MAX);
        prtc_pkg::IDX_KP: s_d.kp = clamp(wval, prtc_pkg::ZERO16, prtc_pkg::GAIN_MAX);
        prtc_pkg::IDX_KI: s_d.ki = clamp(wval, prtc_pkg::ZERO16, prtc_pkg::GAIN_MAX);
        prtc_pkg::IDX_DECEL: s_d.decel = clamp(wval, prtc_pkg::ZERO16, prtc_pkg::DECEL_MAX);
        prtc_pkg::IDX_MASK: s_d.mask = wval[prtc_pkg::ST_W-1:0];
        default: begin
        end
      endcase
    end
    // Sticky status: a new event wins over a write-one-to-clear in the same cycle.
    s_d.status = s_q.status;
    if (s_q.aw_v && s_q.w_v && s_q.aw_idx == prtc_pkg::IDX_STATUS && s_q.wstrb[0]) begin
      s_d.status = s_q.status & ~s_q.wdata[prtc_pkg::ST_W-1:0];
    end
    s_d.status = s_d.status | ev;

    if (s_q.r_v && s_axi_rready) begin
      s_d.r_v = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      s_d.r_v = 1'b1;
      s_d.rresp = mapped(s_axi_araddr[15:2]) ? prtc_pkg::RESP_OKAY : prtc_pkg::RESP_SLVERR;
      unique case (s_axi_araddr[15:2])
        prtc_pkg::IDX_MODE: s_d.rdata = 32'(s_q.mode);
        prtc_pkg::IDX_DIS_LVL: s_d.rdata = 32'(s_q.dis_lvl);
        prtc_pkg::IDX_EN_LVL: s_d.rdata = 32'(s_q.en_lvl);
        prtc_pkg::IDX_RECOV: s_d.rdata = 32'(s_q.recov);
        prtc_pkg::IDX_KP: s_d.rdata = 32'(s_q.kp);
        prtc_pkg::IDX_KI: s_d.rdata = 32'(s_q.ki);
        prtc_pkg::IDX_DECEL: s_d.rdata = 32'(s_q.decel);
        prtc_pkg::IDX_STATUS: s_d.rdata = 32'(s_q.status);
        prtc_pkg::IDX_MASK: s_d.rdata = 32'(s_q.mask);
        prtc_pkg::IDX_STATE: s_d.rdata = {14'h0000, s_q.fsm, freq_out};
        default: s_d.rdata = '0;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.mode <= prtc_pkg::MODE_RST;
      s_q.dis_lvl <= prtc_pkg::DIS_RST;
      s_q.en_lvl <= prtc_pkg::EN_RST;
      s_q.recov <= prtc_pkg::RECOV_RST;
      s_q.kp <= prtc_pkg::KP_RST;
      s_q.ki <= prtc_pkg::KI_RST;
      s_q.decel <= prtc_pkg::DECEL_RST;
      s_q.fsm <= prtc_pkg::PRTC_RUN;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready = !s_q.aw_v && !s_q.b_v;
  assign s_axi_wready = !s_q.w_v && !s_q.b_v;
  assign s_axi_bvalid = s_q.b_v;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = !s_q.r_v;
  assign s_axi_rvalid = s_q.r_v;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign uv_fault = s_q.uv;
  assign irq = |(s_q.status & s_q.mask);
endmodule
`default_nettype wire

// >>> hdl/prtc_pi.sv
// Bus-voltage PI regulator giving a frequency trim for each update.
// Assumes err is positive when the bus sits below its set level.
`timescale 1ns/10ps
`default_nettype none
module prtc_pi (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic active,
  input wire logic upd,
  input wire logic signed [16:0] err,
  input wire logic [15:0] kp,
  input wire logic [15:0] ki,
  output logic [15:0] delta
);
  typedef struct packed {
    logic signed [31:0] integ;
    logic [15:0] delta;
  } prtc_pi_st_type;
  prtc_pi_st_type s_q, s_d;
  logic signed [31:0] integ_n;
  logic signed [31:0] sum;

  always_comb begin
    s_d = s_q;
    integ_n = s_q.integ + 32'(err * $signed({1'b0, ki}));
    if (integ_n < 0) begin
      integ_n = '0;
    end
    sum = 32'(err * $signed({1'b0, kp})) + integ_n;
    if (!active) begin
      s_d = '0;
    end else if (upd) begin
      s_d.integ = integ_n;
      s_d.delta = (sum <= 0) ? prtc_pkg::ZERO16 : 16'(sum >>> prtc_pkg::PI_SHIFT);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign delta = s_q.delta;
endmodule
`default_nettype wire

// >>> hdl/prtc_ramp.sv
// Frequency ramp: moves the output one unit toward the target every step period.
// Assumes step periods of at least one cycle; a trim input can pull the output down.
`timescale 1ns/10ps
`default_nettype none
module prtc_ramp (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [15:0] target,
  input wire logic [31:0] step_cyc,
  input wire logic sub_en,
  input wire logic [15:0] sub_amt,
  output logic [15:0] freq
);
  typedef struct packed {
    logic [31:0] cnt;
    logic [15:0] freq;
  } prtc_ramp_st_type;
  prtc_ramp_st_type s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (sub_en) begin
      s_d.freq = (s_q.freq > sub_amt) ? s_q.freq - sub_amt : prtc_pkg::ZERO16;
      s_d.cnt = '0;
    end else if (run && s_q.freq != target) begin
      if (s_q.cnt + 32'h1 >= step_cyc) begin
        s_d.cnt = '0;
        s_d.freq = (s_q.freq < target) ? s_q.freq + 16'h1 : s_q.freq - 16'h1;
      end else begin
        s_d.cnt = s_q.cnt + 32'h1;
      end
    end else begin
      s_d.cnt = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign freq = s_q.freq;
endmodule
`default_nettype wire

// >>> include/prtc_pkg.sv
// Constants, register map and state types of the power-dip ride-through control.
// Assumes a 250 MHz control clock and bus levels given in 0.1 % of rated DC bus voltage.
//
// Notes on behaviour
// - The mode register selects off (0), constant bus voltage (1) or ramp to stop (2).
// - On a supply loss the motor regenerates so the bus is held near the enable level.
// - While the bus is above the disable level, regulation is suspended.
// - After the supply returns, the recovery delay passes before normal running resumes.
// - In constant-bus mode, recovery ramps back to the target with the acceleration time.
// - In ramp-to-stop mode the drive keeps decelerating to 0 Hz and waits for a new start.
// - The proportional gain is used only in constant-bus mode.
// - An integral coefficient adds to the proportional term of the bus regulator.
// - In ramp-to-stop mode the dip deceleration uses its own dedicated deceleration time.
package prtc_pkg;
  // Register indices; the byte address is four times the index.
  localparam logic [13:0] IDX_MODE = 14'h0d14;
  localparam logic [13:0] IDX_DIS_LVL = 14'h0d15;
  localparam logic [13:0] IDX_EN_LVL = 14'h0d16;
  localparam logic [13:0] IDX_RECOV = 14'h0d17;
  localparam logic [13:0] IDX_KP = 14'h0d18;
  localparam logic [13:0] IDX_KI = 14'h0d19;
  localparam logic [13:0] IDX_DECEL = 14'h0d1a;
  localparam logic [13:0] IDX_STATUS = 14'h0d1c;
  localparam logic [13:0] IDX_MASK = 14'h0d1d;
  localparam logic [13:0] IDX_STATE = 14'h0d1e;
  // Reset values and ranges (levels in 0.1 %, times in 0.1 s).
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam logic [15:0] MODE_MAX = 16'h0002;
  localparam logic [15:0] DIS_RST = 16'h0352;
  localparam logic [15:0] DIS_MIN = 16'h0320;
  localparam logic [15:0] EN_RST = 16'h0320;
  localparam logic [15:0] EN_MIN = 16'h0258;
  localparam logic [15:0] LVL_MAX = 16'h03e8;
  localparam logic [15:0] RECOV_RST = 16'h0005;
  localparam logic [15:0] RECOV_MAX = 16'h03e8;
  localparam logic [15:0] KP_RST = 16'h0032;
  localparam logic [15:0] KI_RST = 16'h001e;
  localparam logic [15:0] GAIN_MAX = 16'h0064;
  localparam logic [15:0] DECEL_RST = 16'h00c8;
  localparam logic [15:0] DECEL_MAX = 16'h0bb8;
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [15:0] UV_TRIP = 16'h01f4;
  // Mode codes.
  localparam logic [15:0] MODE_OFF = 16'h0000;
  localparam logic [15:0] MODE_HOLD = 16'h0001;
  localparam logic [15:0] MODE_STOP = 16'h0002;
  // Status bits.
  localparam int ST_DIP = 0;
  localparam int ST_RET = 1;
  localparam int ST_STOP = 2;
  localparam int ST_UV = 3;
  localparam int ST_W = 4;
  // Timing: a setting unit of 0.1 s and the regulator period of 1 ms.
  localparam int CLK_PERIOD_NS = 4;
  localparam int TENTH_S_NS = 100_000_000;
  localparam int TENTH_S_CYC = TENTH_S_NS / CLK_PERIOD_NS;
  localparam int PI_PERIOD_NS = 1_000_000;
  localparam int PI_PERIOD_CYC = PI_PERIOD_NS / CLK_PERIOD_NS;
  localparam int MAX_FREQ = 5000;
  localparam int PI_SHIFT = 6;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {
    PRTC_RUN = 2'b00,
    PRTC_DIP = 2'b01,
    PRTC_RECOVER = 2'b11,
    PRTC_STOPPED = 2'b10
  } prtc_state_type;
endpackage

// >>> verification/prtc_ctrl_monitor.sv
// Port assertions for the ride-through control top module.
// Assumes a single clock domain; the bind at the foot attaches it to every instance.
`timescale 1ns/10ps
`default_nettype none
module prtc_ctrl_monitor #(
  parameter int TENTH_CYC = 50,
  parameter int PI_CYC = 16
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [15:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] bus_level,
  input wire logic [15:0] freq_out,
  input wire logic uv_fault
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // Bus handshakes and protection output
  // ----------------------------------------
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  function automatic logic mapped(input logic [15:0] a);
    return a[1:0] == 2'b00 && a >= 16'h3450 && a <= 16'h3478 && a != 16'h346c;
  endfunction
  a_wr_answer: assert property (s_wr_both |-> ##2 s_axi_bvalid)
    else $error("write response not on time");
  a_wr_resp_code: assert property (s_wr_both |-> ##2
    s_axi_bresp == (mapped($past(s_axi_awaddr, 2)) ? 2'b00 : 2'b10))
    else $error("write response code wrong");
  a_wr_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_wr_single: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read data not on time");
  a_rd_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  a_rd_single: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  a_uv_track: assert property (1'b1 |=> uv_fault == ($past(bus_level) < 16'h01f4))
    else $error("undervoltage flag does not follow bus");
  a_reset_quiet: assert property ($rose(rst_n) |-> freq_out == 16'h0000 && !uv_fault)
    else $error("outputs not cleared by reset");
endmodule
bind prtc_ctrl prtc_ctrl_monitor #(.TENTH_CYC(TENTH_CYC), .PI_CYC(PI_CYC)) u_mon (
  .ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .bus_level(bus_level), .freq_out(freq_out), .uv_fault(uv_fault)
);
`default_nettype wire

// >>> verification/prtc_grid_model.sv
// Supply grid and regenerating motor as seen from the DC bus.
// Assumes the bench commands outages and the drive's frequency reflects motor speed.
`timescale 1ns/10ps
`default_nettype none
module prtc_grid_model #(
  parameter int NOMINAL = 1000,
  parameter int REGEN = 4
) (
  input wire logic ref_clk,
  input wire logic outage,
  input wire logic [15:0] freq_out,
  output logic [15:0] bus_level,
  output logic supply_lost
);
  int lvl = 1000;
  int prev_f = 0;
  // The bus sags under load without the grid and is refilled by braking energy.
  always @(posedge ref_clk) begin
    if (outage) begin
      lvl = lvl - 1;
      if (int'(freq_out) < prev_f) begin
        lvl = lvl + (prev_f - int'(freq_out)) * REGEN;
      end
    end else begin
      lvl = lvl + 1;
    end
    lvl = (lvl > NOMINAL) ? NOMINAL : ((lvl < 0) ? 0 : lvl);
    prev_f = int'(freq_out);
    supply_lost <= outage;
    bus_level <= 16'(lvl);
  end
endmodule
`default_nettype wire

// >>> verification/testbench.sv
// Self-checking bench: register model, outage scenarios in all three modes.
// Assumes the grid model and the bound monitor are compiled beforehand.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  // ----------------------------------------
  // Stimulus, models and counters
  // ----------------------------------------
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] s_axi_awaddr = 16'h0000;
  logic [15:0] s_axi_araddr = 16'h0000;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic outage = 1'b0;
  logic start_cmd = 1'b0;
  logic [15:0] freq_target = 16'h0000;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic supply_lost, uv_fault, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [31:0] s_axi_rdata, rd;
  logic [15:0] bus_level, freq_out;
  int errors = 0;
  int checks = 0;
  int f0, f1;
  int lo[7] = '{0, 800, 600, 0, 0, 0, 0};
  int hi[7] = '{2, 1000, 1000, 1000, 100, 100, 3000};
  int mdl[7] = '{0, 850, 800, 5, 50, 30, 200};

  always #2 ref_clk = ~ref_clk;

  prtc_ctrl #(.TENTH_CYC(5000), .PI_CYC(16)) u_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .bus_level(bus_level), .supply_lost(supply_lost),
    .start_cmd(start_cmd), .freq_target(freq_target), .accel_time(16'h0001),
    .normal_decel_time(16'h0007), .freq_out(freq_out), .uv_fault(uv_fault), .irq(irq)
  );
  prtc_grid_model u_grid (
    .ref_clk(ref_clk), .outage(outage), .freq_out(freq_out),
    .bus_level(bus_level), .supply_lost(supply_lost)
  );

  // ----------------------------------------
  // Bus cycles and comparisons
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Ready is sampled at the falling edge; it cannot change before the next rising edge.
  task automatic axi_write(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_hs, w_hs, b_hs;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    b_hs = 1'b0;
    while (!b_hs) begin
      @(negedge ref_clk);
      aw_hs = s_axi_awvalid && s_axi_awready;
      w_hs = s_axi_wvalid && s_axi_wready;
      b_hs = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge ref_clk);
      if (aw_hs) s_axi_awvalid <= 1'b0;
      if (w_hs) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic axi_read(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_hs, got;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    got = 1'b0;
    while (!got) begin
      @(negedge ref_clk);
      ar_hs = s_axi_arvalid && s_axi_arready;
      got = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge ref_clk);
      if (ar_hs) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic reg_wr(input int i, input int v);
    logic [1:0] r;
    axi_write({prtc_pkg::IDX_MODE + 14'(i), 2'b00}, 32'(v), r);
    check(32'(r), 32'((i == 7) ? prtc_pkg::RESP_SLVERR : prtc_pkg::RESP_OKAY));
    if (i < 7) mdl[i] = (v < lo[i]) ? lo[i] : ((v > hi[i]) ? hi[i] : v);
  endtask

  task automatic reg_rd(input int i, input logic [31:0] e);
    axi_read({prtc_pkg::IDX_MODE + 14'(i), 2'b00}, rd, rs);
    check(rd, e);
    check(32'(rs), 32'(prtc_pkg::RESP_OKAY));
  endtask

  task automatic cfg(input int m, input int rec);
    int v[7];
    v = '{m, 850, 800, rec, 50, 30, 2};
    for (int i = 0; i < 7; i++) reg_wr(i, v[i]);
  endtask

  task automatic wait_freq(input int f);
    for (int n = 0; n < 20000 && freq_out !== 16'(f); n++) @(negedge ref_clk);
    check(32'(freq_out), 32'(f));
    @(posedge ref_clk);
  endtask

  task automatic chk_irq(input logic e);
    @(negedge ref_clk);
    check(32'(irq), 32'(e));
    @(posedge ref_clk);
  endtask

  task automatic report_and_stop;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    f0 = $urandom(32'h2d32d51b);
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 10; i++) if (i != 7) reg_rd(i, (i < 7) ? 32'(mdl[i]) : 32'h0);
    for (int k = 0; k < 14; k++) begin
      reg_wr(k % 7, $urandom % 4000);
      reg_rd(k % 7, 32'(mdl[k % 7]));
    end
    reg_wr(7, 1);
    reg_rd(0, 32'(mdl[0]));
    // Function off: a dip only raises the undervoltage report.
    cfg(0, 3);
    reg_wr(9, 15);
    f0 = 1000 + $urandom % 1000;
    freq_target <= 16'(f0);
    wait_freq(f0);
    outage <= 1'b1;
    repeat (700) @(posedge ref_clk);
    check(32'(uv_fault), 32'h1);
    reg_rd(10, 32'(f0));
    reg_rd(8, 32'h8);
    chk_irq(1'b1);
    reg_wr(9, 0);
    chk_irq(1'b0);
    reg_wr(9, 15);
    chk_irq(1'b1);
    reg_wr(8, 8);
    chk_irq(1'b0);
    outage <= 1'b0;
    repeat (1100) @(posedge ref_clk);
    // Constant bus voltage: regeneration holds the bus, then recovery and re-acceleration.
    reg_wr(8, 15);
    cfg(1, 3);
    outage <= 1'b1;
    repeat (1000) @(posedge ref_clk);
    check(32'(uv_fault), 32'h0);
    axi_read({prtc_pkg::IDX_STATE, 2'b00}, rd, rs);
    check(32'(rs), 32'(prtc_pkg::RESP_OKAY));
    check(32'(rd[17:16]), 32'h1);
    check(32'(rd[17:16] == 2'b01 && rd[15:0] < 16'(f0)), 32'h1);
    outage <= 1'b0;
    // The last regulator trim may still land just after the supply returns.
    repeat (4) @(posedge ref_clk);
    axi_read({prtc_pkg::IDX_STATE, 2'b00}, rd, rs);
    check(32'(rd[17:16]), 32'h3);
    f1 = int'(rd[15:0]);
    repeat (100) @(posedge ref_clk);
    reg_rd(10, {14'h0, 2'b11, 16'(f1)});
    wait_freq(f0);
    reg_rd(8, 32'h3);
    // Ramp to stop: dedicated deceleration, no restart until a new start request.
    reg_wr(8, 15);
    cfg(2, 3);
    outage <= 1'b1;
    for (int n = 0; n < 2000 && freq_out === 16'(f0); n++) @(negedge ref_clk);
    f1 = int'(freq_out);
    repeat (40) @(negedge ref_clk);
    check(32'(16'(f1) - freq_out), 32'd20);
    @(posedge ref_clk);
    outage <= 1'b0;
    wait_freq(0);
    repeat (50) @(posedge ref_clk);
    reg_rd(10, 32'h0002_0000);
    reg_rd(8, 32'h7);
    start_cmd <= 1'b1;
    @(posedge ref_clk);
    start_cmd <= 1'b0;
    wait_freq(f0);
    report_and_stop;
  end

  initial begin
    #400000;
    errors++;
    report_and_stop;
  end
endmodule
`default_nettype wire
